// File: hdl/fom_pkg.sv
package fom_pkg;
   // Command codes written on the command bus
   localparam logic [7:0] FOM_CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] FOM_CMD_WORD_PGM_A = 8'h10;
   localparam logic [7:0] FOM_CMD_WORD_PGM_B = 8'h40;
   localparam logic [7:0] FOM_CMD_BUF_PGM = 8'hE8;
   localparam logic [7:0] FOM_CMD_ERASE = 8'h20;
   localparam logic [7:0] FOM_CMD_FACT_PGM = 8'h30;
   localparam logic [7:0] FOM_CMD_CONFIRM = 8'hD0;
   localparam logic [7:0] FOM_CMD_SUSPEND = 8'hB0;
   localparam logic [7:0] FOM_CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] FOM_CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] FOM_CMD_READ_ID = 8'h90;
   localparam logic [7:0] FOM_CMD_READ_QUERY = 8'h98;
   localparam logic [7:0] FOM_CMD_LOCK_SETUP = 8'h60;
   localparam logic [7:0] FOM_CMD_OTP_SETUP = 8'hC0;
   localparam logic [7:0] FOM_CMD_LOCK_CONF = 8'h01;
   localparam logic [7:0] FOM_CMD_LOCKDN_CONF = 8'h2F;
   localparam logic [7:0] FOM_CMD_CFG_CONF = 8'h03;

   localparam int FOM_NUM_PART = 4;
   localparam int FOM_PART_W = 2;

   // Chip state class, one-hot, supplied by the write_sequencer
   typedef enum logic [4:0] {
      FOM_CLS_SETUP = 5'h01,
      FOM_CLS_LOCK_SETUP = 5'h02,
      FOM_CLS_OTP_BUSY = 5'h04,
      FOM_CLS_IDLE_BUSY = 5'h08,
      FOM_CLS_PE_BUSY = 5'h10
   } fom_cls_t;

   typedef enum logic [2:0] {
      FOM_SRC_ARRAY = 3'h1,
      FOM_SRC_STATUS = 3'h2,
      FOM_SRC_ID = 3'h4
   } fom_src_t;

   localparam fom_src_t FOM_SRC_RESET = FOM_SRC_ARRAY;

   typedef struct packed {
      logic valid;
      logic [FOM_PART_W-1:0] part;
      logic [7:0] code;
   } fom_cmd_t;

   typedef struct packed {
      logic wr;
      logic sel;
      fom_src_t src;
      logic clr_err;
      logic lock_done;
   } fom_dec_t;
endpackage

// File: hdl/fom_decode.sv
`timescale 1ns/1ns
`default_nettype none
module fom_decode
   import fom_pkg::*;
(
   input wire fom_cls_t i_cls,
   input wire fom_cmd_t i_cmd,
   input wire logic i_op_done,
   output fom_dec_t o_dec
);
   always_comb begin
      o_dec = '0;
      o_dec.src = FOM_SRC_STATUS;
      if (i_cmd.valid) begin
         o_dec.wr = 1'b1;
         case (i_cls)
            FOM_CLS_SETUP: begin
               o_dec.sel = 1'b1; // R1
            end
            FOM_CLS_LOCK_SETUP: begin
               // Confirms finish the lock or config operation and go ready
               o_dec.sel = 1'b1; // R13
               if (i_cmd.code == FOM_CMD_LOCK_CONF || i_cmd.code == FOM_CMD_LOCKDN_CONF ||
                   i_cmd.code == FOM_CMD_CFG_CONF || i_cmd.code == FOM_CMD_CONFIRM) begin
                  o_dec.lock_done = 1'b1; // R11
                  o_dec.src = FOM_SRC_ARRAY;
               end
            end
            FOM_CLS_OTP_BUSY: begin
               if (i_cmd.code == FOM_CMD_READ_ARRAY) begin
                  o_dec.sel = 1'b1;
                  o_dec.src = FOM_SRC_ARRAY;
               end else if (i_cmd.code == FOM_CMD_READ_ID || i_cmd.code == FOM_CMD_READ_QUERY) begin
                  o_dec.sel = 1'b1;
                  o_dec.src = FOM_SRC_ID;
               end else begin
                  o_dec.sel = 1'b1;
               end
            end
            FOM_CLS_IDLE_BUSY, FOM_CLS_PE_BUSY: begin
               case (i_cmd.code)
                  FOM_CMD_READ_ARRAY: begin
                     o_dec.sel = 1'b1;
                     o_dec.src = FOM_SRC_ARRAY; // R2
                  end
                  FOM_CMD_READ_ID, FOM_CMD_READ_QUERY: begin
                     o_dec.sel = 1'b1;
                     o_dec.src = FOM_SRC_ID; // R3
                  end
                  FOM_CMD_OTP_SETUP: begin
                     o_dec.sel = 1'b1; // R4
                  end
                  FOM_CMD_LOCK_SETUP: begin
                     o_dec.sel = 1'b1; // R7
                  end
                  FOM_CMD_READ_STATUS, FOM_CMD_WORD_PGM_A, FOM_CMD_WORD_PGM_B, FOM_CMD_BUF_PGM,
                  FOM_CMD_ERASE, FOM_CMD_FACT_PGM, FOM_CMD_CONFIRM, FOM_CMD_SUSPEND: begin
                     o_dec.sel = 1'b1; // R12
                  end
                  FOM_CMD_CLEAR_STATUS: begin
                     o_dec.sel = 1'b1;
                     o_dec.clr_err = (i_cls == FOM_CLS_IDLE_BUSY); // R10
                  end
                  FOM_CMD_LOCK_CONF, FOM_CMD_LOCKDN_CONF, FOM_CMD_CFG_CONF: begin
                     o_dec.sel = 1'b0; // R5
                  end
                  default: begin
                     o_dec.sel = 1'b0; // R6
                  end
               endcase
            end
            default: begin
               o_dec.sel = 1'b0;
            end
         endcase
      end
      // Completion while one-time-programmable busy keeps the source
      if (i_op_done && i_cls == FOM_CLS_OTP_BUSY && !i_cmd.valid) begin
         o_dec.sel = 1'b0; // R8
      end
   end
endmodule
`default_nettype wire

// File: hdl/fom_mux_next.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// R1 - In any setup, buffer-load, buffer-confirm or factory-program verify state every write selects status.
// R2 - From ready, suspended or busy states the read-array command selects array data.
// R3 - From ready, suspended or busy states either identifier/query code selects identifier data.
// R4 - From ready, suspended or busy states the one-time-programmable setup code selects status.
// R5 - From ready, suspended or busy states the lock, lock-down and configuration confirms keep the source.
// R6 - From ready, suspended or busy states an undefined code keeps the source.
// R7 - From ready, suspended or busy states the lock/configuration setup code selects status.
// R8 - Operation completion during one-time-programmable busy keeps the source.
// R9 - Each partition holds its own source and the chip state never reads it.
// R10 - Clear-status clears error bits only while no program, erase or factory operation runs.
// R11 - Lock, unlock, lock-down and configuration confirms run and then return the chip to ready.
// R12 - From ready, suspended or busy states read-status selects the status register.
// R13 - In lock/configuration setup reads show status until the confirm completes.
module fom_mux_next
   import fom_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire fom_cls_t i_cls,
   input wire fom_cmd_t i_cmd,
   input wire logic i_op_done,
   output var fom_src_t o_src [FOM_NUM_PART],
   output var fom_src_t o_src_cur,
   output logic o_clr_err,
   output logic o_lock_done
);
   typedef struct packed {
      fom_src_t [FOM_NUM_PART-1:0] src;
      fom_src_t cur;
      logic clr_err;
      logic lock_done;
   } fom_state_t;

   fom_state_t state_reg;
   fom_state_t state_next;
   fom_dec_t dec;

   fom_decode u_decode (
      .i_cls(i_cls),
      .i_cmd(i_cmd),
      .i_op_done(i_op_done),
      .o_dec(dec)
   );

   always_comb begin
      state_next = state_reg;
      state_next.clr_err = dec.clr_err; // R10
      state_next.lock_done = dec.lock_done; // R11
      state_next.cur = state_reg.src[i_cmd.part];
      if (dec.sel) begin
         // Only the addressed partition moves; next chip state ignores these
         state_next.src[i_cmd.part] = dec.src; // R9
         state_next.cur = dec.src;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         // Pattern keeps each element typed; a replicated vector would need a cast
         state_reg.src <= '{default: FOM_SRC_RESET};
         state_reg.cur <= FOM_SRC_RESET;
         state_reg.clr_err <= 1'b0;
         state_reg.lock_done <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   genvar g;
   generate
      for (g = 0; g < FOM_NUM_PART; g++) begin : g_out
         assign o_src[g] = state_reg.src[g];
      end
   endgenerate
   assign o_src_cur = state_reg.cur;
   assign o_clr_err = state_reg.clr_err;
   assign o_lock_done = state_reg.lock_done;
endmodule
`default_nettype wire

// File: bench/fom_host.sv
`timescale 1ns/1ns
`default_nettype none
module fom_host
   import fom_pkg::*;
(
   input wire logic i_core_clk,
   output var fom_cmd_t o_cmd
);
   initial o_cmd = '{1'b0, 2'h0, 8'h00};
   task automatic wr(input logic [1:0] p, input logic [7:0] k);
      @(posedge i_core_clk);
      o_cmd <= '{1'b1, p, k};
      @(posedge i_core_clk);
      // Idle bus shows flipped bits, never a stale command
      o_cmd <= '{1'b0, ~p, ~k};
   endtask
endmodule
`default_nettype wire

// File: bench/fom_mux_next_properties.sv
`timescale 1ns/1ns
`default_nettype none
module fom_mux_next_properties
   import fom_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire fom_cls_t i_cls,
   input wire fom_cmd_t i_cmd,
   input wire logic i_op_done,
   input wire fom_src_t o_src [FOM_NUM_PART],
   input wire fom_src_t o_src_cur,
   input wire logic o_clr_err,
   input wire logic o_lock_done
);
   wire logic v = i_cmd.valid;
   wire logic r = i_cls == FOM_CLS_IDLE_BUSY || i_cls == FOM_CLS_PE_BUSY;
   wire logic [7:0] c = i_cmd.code;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_srst);
   property p_set; v && i_cls == FOM_CLS_SETUP |=> o_src_cur == FOM_SRC_STATUS; endproperty
   a_set: assert property (p_set) else $error("setup not status");
   property p_arr; v && r && c == 8'hFF |=> o_src_cur == FOM_SRC_ARRAY; endproperty
   a_arr: assert property (p_arr) else $error("not array");
   property p_id; v && r && c inside {8'h90, 8'h98} |=> o_src_cur == FOM_SRC_ID; endproperty
   a_id: assert property (p_id) else $error("not id");
   property p_st; v && r && c inside {8'hC0, 8'h60, 8'h70} |=> o_src_cur == FOM_SRC_STATUS; endproperty
   a_st: assert property (p_st) else $error("not status");
   property p_kp; v && r && c inside {8'h01, 8'h2F, 8'h03} |=> o_src_cur == $past(o_src[i_cmd.part]); endproperty
   a_kp: assert property (p_kp) else $error("source moved");
   property p_lk; v && i_cls == FOM_CLS_LOCK_SETUP && c == 8'h2F |=> o_lock_done; endproperty
   a_lk: assert property (p_lk) else $error("no lock done");
   property p_otp; i_op_done && !v && i_cls == FOM_CLS_OTP_BUSY |=> $stable(o_src_cur); endproperty
   a_otp: assert property (p_otp) else $error("otp done moved");
   property p_clr; v && i_cls == FOM_CLS_PE_BUSY |=> !o_clr_err; endproperty
   a_clr: assert property (p_clr) else $error("clear while busy");
endmodule
bind fom_mux_next fom_mux_next_properties chk (.i_core_clk, .i_srst, .i_cls, .i_cmd, .i_op_done, .o_src,
   .o_src_cur, .o_clr_err, .o_lock_done);
`default_nettype wire

// File: bench/tb_fom_mux_next.sv
`timescale 1ns/1ns
`default_nettype none
module tb_fom_mux_next;
   import fom_pkg::*;
   logic i_core_clk = 1'b0;
   logic i_srst = 1'b1;
   fom_cls_t i_cls = FOM_CLS_IDLE_BUSY;
   logic i_op_done = 1'b0;
   fom_cmd_t i_cmd;
   fom_src_t o_src [FOM_NUM_PART];
   fom_src_t o_src_cur;
   logic o_clr_err;
   logic o_lock_done;
   int n_mismatch = 0;
   int total_checks = 0;
   int cyc = 0;
   always #4 i_core_clk = ~i_core_clk;
   fom_host host (.i_core_clk, .o_cmd(i_cmd));
   fom_mux_next uut (.i_core_clk, .i_srst, .i_cls, .i_cmd, .i_op_done, .o_src, .o_src_cur, .o_clr_err, .o_lock_done);
   task automatic chk(input logic [2:0] got, input logic [2:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic wr(input fom_cls_t k, input logic [1:0] p, input logic [7:0] c, input fom_src_t e);
      @(posedge i_core_clk);
      i_cls <= k;
      host.wr(p, c);
      #1;
      chk(o_src[p], e);
      chk(o_src_cur, e);
   endtask
   task automatic t_ready();
      logic [7:0] tc [12] = '{8'hFF, 8'h01, 8'h90, 8'h2F, 8'h98, 8'h03, 8'h55, 8'hC0, 8'hFF, 8'h60, 8'h02, 8'h70};
      fom_src_t te [12] = '{FOM_SRC_ARRAY, FOM_SRC_ARRAY, FOM_SRC_ID, FOM_SRC_ID, FOM_SRC_ID, FOM_SRC_ID,
         FOM_SRC_ID, FOM_SRC_STATUS, FOM_SRC_ARRAY, FOM_SRC_STATUS, FOM_SRC_STATUS, FOM_SRC_STATUS};
      for (int j = 0; j < 2; j++) begin
         for (int i = 0; i < 12; i++) begin
            wr(j ? FOM_CLS_PE_BUSY : FOM_CLS_IDLE_BUSY, 2'h1, tc[i], te[i]);
         end
      end
      $display("t_ready done");
   endtask
   task automatic t_setup();
      chk(o_src[0], FOM_SRC_ARRAY);
      wr(FOM_CLS_SETUP, 2'h2, 8'hFF, FOM_SRC_STATUS);
      wr(FOM_CLS_SETUP, 2'h2, 8'h90, FOM_SRC_STATUS);
      chk(o_src[1], FOM_SRC_STATUS);
      wr(FOM_CLS_LOCK_SETUP, 2'h3, 8'hFF, FOM_SRC_STATUS);
      wr(FOM_CLS_LOCK_SETUP, 2'h3, 8'h2F, FOM_SRC_ARRAY);
      chk({2'h0, o_lock_done}, 3'h1);
      $display("t_setup done");
   endtask
   task automatic t_otp_clr();
      wr(FOM_CLS_OTP_BUSY, 2'h0, 8'h90, FOM_SRC_ID);
      @(posedge i_core_clk);
      i_op_done <= 1'b1;
      @(posedge i_core_clk);
      i_op_done <= 1'b0;
      #1;
      chk(o_src[0], FOM_SRC_ID);
      wr(FOM_CLS_PE_BUSY, 2'h0, 8'h50, FOM_SRC_STATUS);
      chk({2'h0, o_clr_err}, 3'h0);
      wr(FOM_CLS_IDLE_BUSY, 2'h0, 8'h50, FOM_SRC_STATUS);
      chk({2'h0, o_clr_err}, 3'h1);
      $display("t_otp_clr done");
   endtask
   always @(posedge i_core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   initial begin
      repeat (20) @(posedge i_core_clk);
      i_srst <= 1'b0;
      t_ready();
      t_setup();
      t_otp_clr();
      end_of_test();
   end
endmodule
`default_nettype wire
